// ---- pfm_consts.svh ----
// offsets, field layout, reset values and select codes of the pin mux
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH
`define PFM_NUM_REGS       20
`define PFM_REG_STRIDE     4
`define PFM_ADDR_W         12
`define PFM_DATA_W         32
`define PFM_FIELD_W        4
`define PFM_CODES          16
`define PFM_NUM_PINS       7
`define PFM_TOP_FIELD_LSB  28
`define PFM_SEL_RESET      32'h0000_0000
`define PFM_CODE_0         4'h0
`define PFM_CODE_1         4'h1
`define PFM_CODE_2         4'h2
`define PFM_CODE_4         4'h4
`define PFM_CODE_8         4'h8
`endif

// ---- pfm_pkg.sv ----
// types and the per-pin function table of the pin mux
`include "pfm_consts.svh"
package pfm_pkg;
    typedef enum {
        FN_LOW_POWER_INDICATOR, FN_CLOCK_ALARM_OUT, FN_SERIAL2_CLEAR_TO_SEND,
        FN_GENERAL_IO_BANK0_BIT8, FN_REALTIME_UNIT0_INPUT16,
        FN_AUDIO_MUTE_OUT, FN_REALTIME_UNIT0_OUTPUT16,
        FN_SERIAL2_REQUEST_TO_SEND, FN_GENERAL_IO_BANK0_BIT9,
        FN_AUDIO_TX_HIGH_CLOCK, FN_USB_REFERENCE_CLOCK_IN,
        FN_SERIAL1_CLEAR_TO_SEND, FN_GENERAL_IO_BANK0_BIT10,
        FN_REALTIME_UNIT0_INPUT18, FN_AUDIO_RX_HIGH_CLOCK,
        FN_REALTIME_UNIT0_OUTPUT18, FN_SERIAL1_REQUEST_TO_SEND,
        FN_GENERAL_IO_BANK0_BIT11, FN_REALTIME_UNIT0_INPUT19,
        FN_AUDIO_TX_FRAME_SYNC, FN_GENERAL_IO_BANK0_BIT12,
        FN_REALTIME_UNIT0_INPUT20, FN_AUDIO_RX_FRAME_SYNC,
        FN_GENERAL_IO_BANK0_BIT13, FN_REALTIME_UNIT0_INPUT21,
        FN_AUDIO_TX_BIT_CLOCK, FN_REALTIME_UNIT0_OUTPUT19,
        FN_GENERAL_IO_BANK0_BIT14, FN_COUNT
    } pfm_func_t;

    typedef logic [`PFM_FIELD_W-1:0] pfm_sel_t;

    // returns the function index for a pin and code, -1 when reserved
    function automatic int pfm_map(input int pin, input pfm_sel_t code);
        int fn;
        fn = -1;
        case (pin)
            0: case (code)
                `PFM_CODE_0: fn = FN_LOW_POWER_INDICATOR;
                `PFM_CODE_2: fn = FN_CLOCK_ALARM_OUT;
                `PFM_CODE_4: fn = FN_SERIAL2_CLEAR_TO_SEND;
                `PFM_CODE_8: fn = FN_GENERAL_IO_BANK0_BIT8;
                default:     fn = -1;
            endcase
            1: case (code)
                `PFM_CODE_0: fn = FN_REALTIME_UNIT0_INPUT16;
                `PFM_CODE_1: fn = FN_AUDIO_MUTE_OUT;
                `PFM_CODE_2: fn = FN_REALTIME_UNIT0_OUTPUT16;
                `PFM_CODE_4: fn = FN_SERIAL2_REQUEST_TO_SEND;
                `PFM_CODE_8: fn = FN_GENERAL_IO_BANK0_BIT9;
                default:     fn = -1;
            endcase
            2: case (code)
                `PFM_CODE_1: fn = FN_AUDIO_TX_HIGH_CLOCK;
                `PFM_CODE_2: fn = FN_USB_REFERENCE_CLOCK_IN;
                `PFM_CODE_4: fn = FN_SERIAL1_CLEAR_TO_SEND;
                `PFM_CODE_8: fn = FN_GENERAL_IO_BANK0_BIT10;
                default:     fn = -1;
            endcase
            3: case (code)
                `PFM_CODE_0: fn = FN_REALTIME_UNIT0_INPUT18;
                `PFM_CODE_1: fn = FN_AUDIO_RX_HIGH_CLOCK;
                `PFM_CODE_2: fn = FN_REALTIME_UNIT0_OUTPUT18;
                `PFM_CODE_4: fn = FN_SERIAL1_REQUEST_TO_SEND;
                `PFM_CODE_8: fn = FN_GENERAL_IO_BANK0_BIT11;
                default:     fn = -1;
            endcase
            4: case (code)
                `PFM_CODE_0: fn = FN_REALTIME_UNIT0_INPUT19;
                `PFM_CODE_1: fn = FN_AUDIO_TX_FRAME_SYNC;
                `PFM_CODE_8: fn = FN_GENERAL_IO_BANK0_BIT12;
                default:     fn = -1;
            endcase
            5: case (code)
                `PFM_CODE_0: fn = FN_REALTIME_UNIT0_INPUT20;
                `PFM_CODE_1: fn = FN_AUDIO_RX_FRAME_SYNC;
                `PFM_CODE_8: fn = FN_GENERAL_IO_BANK0_BIT13;
                default:     fn = -1;
            endcase
            6: case (code)
                `PFM_CODE_0: fn = FN_REALTIME_UNIT0_INPUT21;
                `PFM_CODE_1: fn = FN_AUDIO_TX_BIT_CLOCK;
                `PFM_CODE_4: fn = FN_REALTIME_UNIT0_OUTPUT19;
                `PFM_CODE_8: fn = FN_GENERAL_IO_BANK0_BIT14;
                default:     fn = -1;
            endcase
            default: fn = -1;
        endcase
        return fn;
    endfunction
endpackage

// ---- pfm_pin_slot.sv ----
// one multiplexed pin: picks the driving function by its select field
`timescale 1ns/1ps
`include "pfm_consts.svh"
module pfm_pin_slot
    import pfm_pkg::*;
#(
    parameter int PIN = 0
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    input  wire logic [3:0]          sel,
    input  wire logic [FN_COUNT-1:0] func_out,
    input  wire logic [FN_COUNT-1:0] func_oe_n,
    output logic                     pad_out,
    output logic                     pad_oe_n
);
    // a pin beyond the table has no function list to steer
    if (PIN < 0 || PIN >= `PFM_NUM_PINS) begin : g_bad_pin
        $error("pin index out of range");
    end

    typedef struct packed {
        logic out;
        logic oe_n;
    } pfm_slot_state_t;

    pfm_slot_state_t state;
    pfm_slot_state_t next_state;
    logic [`PFM_CODES-1:0] cand_out;
    logic [`PFM_CODES-1:0] cand_oe_n;

    // ==================================================
    // candidate table, one entry per code
    genvar c;
    generate
        for (c = 0; c < `PFM_CODES; c++) begin : g_code
            localparam int FN = pfm_map(PIN, pfm_sel_t'(c));
            if (FN >= 0) begin : g_used
                assign cand_out[c]  = func_out[FN];
                assign cand_oe_n[c] = func_oe_n[FN];
            end else begin : g_rsvd
                // reserved code leaves the pad undriven
                assign cand_out[c]  = 1'b0;
                assign cand_oe_n[c] = 1'b1;
            end
        end
    endgenerate

    // ==================================================
    // output register
    always_comb begin
        next_state      = state;
        next_state.out  = cand_out[sel];
        next_state.oe_n = cand_oe_n[sel];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{out: 1'b0, oe_n: 1'b1};
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign pad_out  = state.out;
    assign pad_oe_n = state.oe_n;
endmodule

// ---- pfm_top.sv ----
// pin function multiplexer: select registers on apb and pad steering
// Overview of operation
// - each pin selected independently of others
// - 4-bit field per pin, twenty registers
// - field steers only pad output, enable
// - pin input reaches all sharers always
// - no check that selection suits peripherals
// - bits 31-28 codes 0,2,4,8 map
// - bits 27-24 codes 0,1,2,4,8 map
// - bits 23-20 codes 1,2,4,8 map
// - bits 19-16 codes 0,1,2 map
// - bits 19-16 codes 4,8 map
// - bits 15-12 codes 0,1,8 map
// - bits 11-8 codes 0,1,8 map
// - bits 7-4 codes 0,1,4,8 map
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "pfm_consts.svh"
module pfm_top
    import pfm_pkg::*;
#(
    parameter int NUM_REGS = `PFM_NUM_REGS,
    parameter int ADDR_W   = `PFM_ADDR_W
) (
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    input  wire logic                     clk_en,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [`PFM_DATA_W-1:0]   pwdata,
    output logic                          pready,
    output logic [`PFM_DATA_W-1:0]        prdata,
    output logic                          pslverr,
    input  wire logic [FN_COUNT-1:0]      func_out,
    input  wire logic [FN_COUNT-1:0]      func_oe_n,
    input  wire logic [`PFM_NUM_PINS-1:0] pad_in,
    output logic [`PFM_NUM_PINS-1:0]      pad_out,
    output logic [`PFM_NUM_PINS-1:0]      pad_oe_n,
    output logic [`PFM_NUM_PINS-1:0]      pin_to_periph
);
    if (NUM_REGS < 1 || NUM_REGS * `PFM_REG_STRIDE > (1 << ADDR_W))
    begin : g_bad_regs
        $error("register count does not fit the address space");
    end
    if (ADDR_W < 3 || ADDR_W > 30) begin : g_bad_addr
        $error("unsupported address width");
    end

    typedef struct packed {
        logic [NUM_REGS-1:0][`PFM_DATA_W-1:0] sel_reg;
        logic                                 ready;
        logic [`PFM_DATA_W-1:0]               rdata;
        logic                                 err;
        logic [`PFM_NUM_PINS-1:0]             pin_in;
    } pfm_state_t;

    pfm_state_t state;
    pfm_state_t next_state;

    // ==================================================
    // address decode
    logic [ADDR_W-3:0] word_idx;
    logic              addr_ok;

    assign word_idx = paddr[ADDR_W-1:2];
    // misaligned or beyond the last register answers with an error
    assign addr_ok  = (paddr[1:0] == 2'h0) &&
                      (int'(word_idx) < NUM_REGS);

    // ==================================================
    // register file and apb slave
    always_comb begin
        next_state = state;
        // pad input is registered once and fanned out unconditionally
        next_state.pin_in = pad_in;
        if (psel && penable && !state.ready) begin
            next_state.ready = 1'b1;
            next_state.err   = !addr_ok;
            next_state.rdata = addr_ok ? state.sel_reg[word_idx]
                                       : 32'h0000_0000;
        end else if (psel && penable && state.ready) begin
            next_state.ready = 1'b0;
            next_state.err   = 1'b0;
            if (pwrite && addr_ok) begin
                // any code accepted, reserved ones included
                next_state.sel_reg[word_idx] = pwdata;
            end
        end else begin
            next_state.ready = 1'b0;
            next_state.err   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state.sel_reg <= '{default: `PFM_SEL_RESET};
            state.ready   <= 1'b0;
            state.rdata   <= 32'h0000_0000;
            state.err     <= 1'b0;
            state.pin_in  <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign pready        = state.ready;
    assign prdata        = state.rdata;
    assign pslverr       = state.err;
    assign pin_to_periph = state.pin_in;

    // ==================================================
    // pad steering, one slot per field in bits 31-4 of the first register
    // only the first register's pins have a known function table;
    // the other registers store their value for software only
    genvar p;
    generate
        for (p = 0; p < `PFM_NUM_PINS; p++) begin : g_pin
            localparam int LSB = `PFM_TOP_FIELD_LSB - `PFM_FIELD_W * p;
            logic [`PFM_FIELD_W-1:0] field;
            assign field = state.sel_reg[0][LSB +: `PFM_FIELD_W];
            pfm_pin_slot #(
                .PIN       (p)
            ) u_slot (
                .ref_clk   (ref_clk),
                .reset_n   (reset_n),
                .clk_en    (clk_en),
                .sel       (field),
                .func_out  (func_out),
                .func_oe_n (func_oe_n),
                .pad_out   (pad_out[p]),
                .pad_oe_n  (pad_oe_n[p])
            );
        end
    endgenerate
endmodule

// ---- pfm_top_monitor.sv ----
// checker of apb answers and pad timing of the pin mux
`timescale 1ns/1ps
module pfm_top_monitor
    import pfm_pkg::*;
#(
    parameter int NUM_REGS = 20,
    parameter int ADDR_W   = 12
) (
    input wire logic              ref_clk,
    input wire logic              reset_n,
    input wire logic              clk_en,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic [6:0]        pad_in,
    input wire logic [6:0]        pad_out,
    input wire logic [6:0]        pad_oe_n,
    input wire logic [6:0]        pin_to_periph
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire logic acc = clk_en && psel && penable && !pready;
    wire logic bad = paddr >= NUM_REGS * 4 || paddr[1:0] != 2'h0;
    // ==========================================
    // bus answers
    property p_rdy_wait; acc |=> pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait)
        else $error("no answer after one wait state");
    property p_rdy_one; clk_en && pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one)
        else $error("ready held too long");
    property p_bad; acc && bad |=> pslverr && prdata == 32'h0; endproperty
    a_bad: assert property (p_bad)
        else $error("bad address not refused");
    property p_good; acc && !bad |=> pready && !pslverr; endproperty
    a_good: assert property (p_good)
        else $error("mapped register refused");
    property p_err_pair; pslverr |-> pready; endproperty
    a_err_pair: assert property (p_err_pair)
        else $error("error without ready");
    // ==========================================
    // pads
    // the flop still sits in reset at the release edge itself
    property p_route;
        reset_n && clk_en |=> pin_to_periph == $past(pad_in);
    endproperty
    a_route: assert property (p_route)
        else $error("pin input not passed on");
    property p_rst;
        $rose(reset_n) |-> pad_oe_n == 7'h7f && !pready && prdata == 0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad state after reset");
    property p_freeze;
        !clk_en |=> $stable(pad_out) && $stable(pad_oe_n);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("pads moved while frozen");
endmodule
bind pfm_top pfm_top_monitor #(.NUM_REGS(NUM_REGS), .ADDR_W(ADDR_W)) u_mon (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pin_to_periph(pin_to_periph));

// ---- pfm_periph_model.sv ----
// model of the peripherals and pad buffers around the pin mux
`timescale 1ns/1ps
module pfm_periph_model
    import pfm_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           reset_n,
    output logic [FN_COUNT-1:0] func_out,
    output logic [FN_COUNT-1:0] func_oe_n,
    output logic [6:0]          pad_in
);
    logic [31:0] s;
    // fresh pattern every cycle so a stale pick shows up
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) s <= 32'h1234_5678;
        else s <= s * 32'h0019_660d + 32'h3c6e_f35f;
    end
    assign func_out  = s[27:0];
    assign func_oe_n = s[31:4];
    assign pad_in    = s[30:24];
endmodule

// ---- tb.sv ----
// self-checking bench of the pin mux: apb tasks and pad sampling
`timescale 1ns/1ps
`include "pfm_consts.svh"
module tb;
    import pfm_pkg::*;
    logic        ref_clk = 0, reset_n = 0, clk_en = 1, er;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, w;
    wire logic   pready, pslverr;
    wire logic [31:0] prdata;
    wire logic [FN_COUNT-1:0] fo, foe;
    wire logic [6:0]  pin, pout, poen, pper;
    logic [FN_COUNT-1:0] vf, vo;
    logic [6:0]  vi;
    int          n_errors = 0, num_checks = 0, cyc = 0;
    logic [15:0] msk [7] = '{16'h0115, 16'h0117, 16'h0116, 16'h0117,
                             16'h0103, 16'h0103, 16'h0113};
    int          base [7] = '{0, 4, 9, 13, 18, 21, 24};
    pfm_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .func_out(fo), .func_oe_n(foe), .pad_in(pin),
        .pad_out(pout), .pad_oe_n(poen), .pin_to_periph(pper));
    pfm_periph_model u_per (.ref_clk(ref_clk), .reset_n(reset_n),
        .func_out(fo), .func_oe_n(foe), .pad_in(pin));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done;
        end
    end
    // ==========================================
    // tasks
    task automatic test_done;
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // reserved codes have no bit in the mask and release the pad
    function automatic int efn(int p, logic [3:0] c);
        int f;
        if (!msk[p][c]) return -1;
        f = base[p];
        for (int i = 0; i < c; i++) f += int'(msk[p][i]);
        return f;
    endfunction
    // entered at the edge after the write lands, so the new pick is due now
    task automatic pads(input logic [31:0] x);
        int f;
        repeat (3) begin
            vf = fo; vo = foe; vi = pin;
            @(negedge ref_clk);
            for (int p = 0; p < 7; p++) begin
                f = efn(p, x[31-4*p -: 4]);
                chk("pad_out", (f < 0) ? 1'b0 : vf[f], pout[p]);
                chk("pad_oe_n", (f < 0) ? 1'b1 : vo[f], poen[p]);
            end
            chk("pin_to_periph", vi, pper);
            @(posedge ref_clk);
        end
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        apb(0, 12'h000, 0);
        chk("reg0 reset", `PFM_SEL_RESET, rd);
        for (int k = 0; k < 18; k++) begin
            w = k < 16 ? {8{k[3:0]}} : (k == 16 ? 32'h2481_1140 : 32'h8048_8018);
            apb(1, 12'h000, w);
            pads(w);
            apb(0, 12'h000, 0);
            chk("reg0", w, rd);
        end
        apb(1, 12'h04c, 32'h5a5a_c3c3);
        apb(0, 12'h04c, 0);
        chk("reg19", 32'h5a5a_c3c3, rd);
        chk("reg19 slverr", 0, er);
        apb(1, 12'h050, 32'hffff_ffff);
        chk("slverr", 1, er);
        apb(1, 12'h002, 32'h0);
        chk("slverr", 1, er);
        apb(0, 12'h002, 0);
        chk("err rdata", 0, rd);
        apb(0, 12'h000, 0);
        chk("reg0 kept", w, rd);
        clk_en <= 1'b0;
        @(posedge ref_clk);
        vi = pout;
        repeat (3) @(posedge ref_clk);
        chk("frozen pad_out", vi, pout);
        clk_en <= 1'b1;
        @(posedge ref_clk);
        test_done;
    end
endmodule
